/* dv/cmc_host_model.sv */
`timescale 1ns/10ps
module cmc_host_model (
	output logic      spi_clk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	logic sdo_w;

	assign sdo_w = sdo_oe ? sdo_o : 1'bz;

	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0; // Pulldown level while undriven
	end

	// Clock runs only inside a frame; nbit below 16 breaks framing on purpose
	task automatic xfer(input logic [15:0] tx, input int nbit,
		output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = 1'b0;
		#230;
		for (int i = 15; i > 15 - nbit; i--) begin
			spi_clk = 1'b1;
			sdi = tx[i];
			#80;
			rx[i] = sdo_w;
			spi_clk = 1'b0;
			#80;
		end
		sdi = 1'b0;
		#80;
		cs_n = 1'b1;
		#400;
	endtask
endmodule // cmc_host_model

/* dv/test_contact_monitor_control_port.sv */
`timescale 1ns/10ps
module test_contact_monitor_control_port;
	localparam int WD1 = 40;
	localparam int WD2 = 80;
	localparam int RST_LEN = 10;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        spi_clk, cs_n, sdi, sdo_o, sdo_oe;
	logic        shutdown_n = 1'b1;
	logic        regulator_on_n = 1'b1;
	logic        regulator_hold_n = 1'b1;
	logic        watchdog_kick = 1'b0;
	logic        regulator_output_low = 1'b0;
	logic        kick_en = 1'b1;
	logic [7:0]  contact = 8'h00;
	logic        direct_out_0, direct_out_1, regulator_enable;
	logic        shutdown_mode, alert_n_oe, reset_n_oe;
	logic        alert_n_o, reset_n_o;
	logic [15:0] rd;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          kc = 0;

	cmc_top #(.WD1_CYCLES(WD1), .WD2_CYCLES(WD2), .RST_CYCLES(RST_LEN)) dut (
		.clk_sys, .rst, .spi_clk, .cs_n, .sdi, .sdo_o, .sdo_oe, .shutdown_n,
		.regulator_on_n, .regulator_hold_n, .watchdog_kick,
		.regulator_output_low, .contact, .direct_out_0, .direct_out_1,
		.regulator_enable, .shutdown_mode, .alert_n_o, .alert_n_oe,
		.reset_n_o, .reset_n_oe);

	cmc_host_model host (.spi_clk, .cs_n, .sdi, .sdo_o, .sdo_oe);

	always #25 clk_sys = ~clk_sys;

	// Background kick keeps the watchdog quiet outside its own test
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		kc <= kc + 1;
		if (kick_en && kc % 10 == 0)
			watchdog_kick <= ~watchdog_kick;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Sample just past the edge so its updates have landed
	task automatic cw(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic t_regulator();
		@(posedge clk_sys) shutdown_n <= 1'b0;
		cw(5);
		chk({regulator_enable, shutdown_mode}, 16'h0001, "sd");
		@(posedge clk_sys) shutdown_n <= 1'b1;
		regulator_on_n <= 1'b0;
		cw(5);
		chk({regulator_enable, shutdown_mode}, 16'h0002, "on");
		@(posedge clk_sys) regulator_on_n <= 1'b1;
		cw(5);
		chk(regulator_enable, 16'h0001, "hold");
		@(posedge clk_sys) regulator_hold_n <= 1'b0;
		cw(5);
		chk(regulator_enable, 16'h0000, "off");
		@(posedge clk_sys) regulator_on_n <= 1'b0;
		cw(5);
		chk(regulator_enable, 16'h0001, "on wins");
		@(posedge clk_sys) shutdown_n <= 1'b0;
		cw(5);
		chk(regulator_enable, 16'h0000, "sd wins");
		@(posedge clk_sys) shutdown_n <= 1'b1;
		regulator_on_n <= 1'b1;
		cw(5);
		$display("done: regulator");
	endtask

	task automatic t_pass_read();
		@(posedge clk_sys) contact <= 8'ha6;
		cw(6);
		chk({direct_out_1, direct_out_0}, 16'h0002, "dir");
		chk(alert_n_oe, 16'h0001, "alert");
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h00a4, "status");
		chk(sdo_oe, 16'h0000, "sdo off");
		chk(alert_n_oe, 16'h0000, "read clr");
		@(posedge clk_sys) contact <= 8'ha5;
		cw(8);
		chk(alert_n_oe, 16'h0000, "pass alert");
		chk({direct_out_1, direct_out_0}, 16'h0001, "dir");
		$display("done: pass_read");
	endtask

	// Every full frame rewrites the command, so reads resend it
	task automatic t_command();
		host.xfer(16'h0110, 16, rd);
		cw(4);
		chk({direct_out_1, direct_out_0}, 16'h0003, "wet");
		host.xfer(16'h0110, 16, rd);
		chk(rd, 16'h00a5, "status wet");
		@(posedge clk_sys) contact <= 8'hb5;
		cw(8);
		chk(alert_n_oe, 16'h0000, "masked");
		host.xfer(16'h0000, 8, rd);
		cw(4);
		chk({direct_out_1, direct_out_0}, 16'h0003, "short");
		@(posedge clk_sys) contact <= 8'hb4;
		cw(8);
		chk(alert_n_oe, 16'h0001, "ch0 alert");
		host.xfer(16'h0000, 16, rd);
		cw(4);
		chk({direct_out_1, direct_out_0}, 16'h0000, "dir");
		chk(alert_n_oe, 16'h0000, "read clr");
		$display("done: command");
	endtask

	task automatic t_watchdog();
		cw(100);
		chk({alert_n_oe, reset_n_oe}, 16'h0000, "kicked");
		@(posedge clk_sys iff kc % 10 == 0) kick_en <= 1'b0;
		cw(WD1 - 2);
		chk(alert_n_oe, 16'h0000, "early");
		cw(10);
		chk({alert_n_oe, reset_n_oe}, 16'h0002, "wd1");
		cw(WD2 - 50);
		chk(reset_n_oe, 16'h0000, "early rst");
		cw(10);
		chk({alert_n_oe, reset_n_oe}, 16'h0001, "wd2");
		chk({alert_n_o, reset_n_o}, 16'h0000, "od level");
		@(posedge clk_sys) kick_en <= 1'b1;
		cw(RST_LEN + 12);
		chk(reset_n_oe, 16'h0000, "pulse end");
		@(posedge clk_sys) regulator_output_low <= 1'b1;
		cw(5);
		chk(reset_n_oe, 16'h0001, "low reg");
		@(posedge clk_sys) regulator_output_low <= 1'b0;
		cw(5);
		chk(reset_n_oe, 16'h0000, "reg ok");
		$display("done: watchdog");
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		chk({sdo_oe, direct_out_1, direct_out_0, regulator_enable,
			shutdown_mode, alert_n_oe, reset_n_oe}, 16'h0034, "reset");
		@(posedge clk_sys) rst <= 1'b0;
		cw(4);
		$display("done: reset");
		t_regulator();
		t_pass_read();
		t_command();
		t_watchdog();
		wrap_up();
	end
endmodule // test_contact_monitor_control_port

/* hw/cmc_spi_link.sv */
`timescale 1ns/10ps
module cmc_spi_link (
	input  wire logic  rst,
	input  wire logic  spi_clk,
	input  wire logic  cs_n,
	input  wire logic  sdi,
	output      logic  sdo_o,
	output      logic  sdo_oe,
	cmc_link_if.link   lk
);
	logic        link_clr;
	logic        in_frame_reg;
	logic        started_reg;
	logic [15:0] tx_sh_reg;

	// Chip select high ends the frame at once
	assign link_clr = rst | cs_n;

	always_ff @(negedge spi_clk or posedge link_clr) begin
		if (link_clr) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	// Word and count survive chip select rising, for the core to take
	always_ff @(negedge spi_clk or posedge rst) begin
		if (rst) begin
			lk.rx_word  <= 16'h0000;
			lk.rx_count <= 5'h00;
		end else if (!cs_n) begin
			// Undriven pin resolves low at the pad
			lk.rx_word <= {lk.rx_word[14:0], sdi};
			if (!in_frame_reg) begin
				lk.rx_count <= 5'h01;
			end else if (lk.rx_count != cmc_pkg::COUNT_MAX) begin
				lk.rx_count <= lk.rx_count + 5'h01;
			end
		end
	end

	// First rising edge loads the snapshot and shows its top bit
	always_ff @(posedge spi_clk or posedge link_clr) begin
		if (link_clr) begin
			started_reg <= 1'b0;
			tx_sh_reg   <= 16'h0000;
			sdo_o       <= 1'b0;
			sdo_oe      <= 1'b0;
		end else begin
			started_reg <= 1'b1;
			sdo_oe      <= 1'b1;
			if (!started_reg) begin
				sdo_o     <= lk.tx_word[15];
				tx_sh_reg <= {lk.tx_word[14:0], 1'b0};
			end else begin
				sdo_o     <= tx_sh_reg[15];
				tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
			end
		end
	end

	// Frame flag keeps the frame's first rising edge, before SDO is enabled, out of the check
	AST_SDO_ENABLED: assert property (
		@(posedge spi_clk) disable iff (rst)
		in_frame_reg && !cs_n |-> sdo_oe
	) else $error("SDO not driven inside a frame");

	AST_SDO_SHIFT: assert property (
		@(posedge spi_clk) disable iff (rst)
		(started_reg && !cs_n) ##1 (!cs_n && in_frame_reg)
		|-> sdo_o == $past(tx_sh_reg[15])
	) else $error("SDO did not advance by one bit");

endmodule // cmc_spi_link

/* hw/cmc_top.sv */
// What this block does
// - A low shutdown input puts the block in shutdown and turns the regulator off; high resumes.
// - The regulator is enabled while the active-low regulator-on input is low.
// - The active-low hold input, with regulator-on, decides when the regulator turns off.
// - Clock activity is ignored for shifting while chip select is high.
// - The shifted word enters the command register only on the rising edge of chip select.
// - While chip select is low, SDO takes the next bit on each rising clock edge.
// - SDO is high impedance whenever chip select is high.
// - While chip select is low, SDI is sampled on each falling clock edge.
// - The reset output goes low on the second watchdog timeout or a low regulator output.
// - With wetting disabled, direct outputs 0 and 1 follow contacts 0 and 1.
// - Every rise or fall of the watchdog kick outside the reset pulse restarts the watchdog.
// - No kick by the first timeout raises alert; by the second, reset pulses and alert drops.
// - A serial read releases a contact-change alert; a watchdog alert stays until a kick or the second timeout.
// - Pass-through contacts are left out of status and never raise alert.
`timescale 1ns/10ps
module cmc_top #(
	parameter int WD1_CYCLES = cmc_pkg::WD1_CYCLES,
	parameter int WD2_CYCLES = cmc_pkg::WD2_CYCLES,
	parameter int RST_CYCLES = cmc_pkg::RST_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       spi_clk,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output wire logic       sdo_o,
	output wire logic       sdo_oe,
	input  wire logic       shutdown_n,
	input  wire logic       regulator_on_n,
	input  wire logic       regulator_hold_n,
	input  wire logic       watchdog_kick,
	input  wire logic       regulator_output_low,
	input  wire logic [7:0] contact,
	output      logic       direct_out_0,
	output      logic       direct_out_1,
	output      logic       regulator_enable,
	output      logic       shutdown_mode,
	output      logic       alert_n_o,
	output      logic       alert_n_oe,
	output      logic       reset_n_o,
	output      logic       reset_n_oe
);
	localparam logic [21:0] WD1_LAST = 22'(WD1_CYCLES - 1);
	localparam logic [21:0] WD2_LAST = 22'(WD2_CYCLES - 1);
	localparam logic [21:0] RST_LAST = 22'(RST_CYCLES - 1);

	cmc_link_if lk ();

	cmc_spi_link u_link (
		.rst     (rst),
		.spi_clk (spi_clk),
		.cs_n    (cs_n),
		.sdi     (sdi),
		.sdo_o   (sdo_o),
		.sdo_oe  (sdo_oe),
		.lk      (lk.link)
	);

	// Pin synchronisers
	logic [2:0] cs_sync_reg;
	logic [1:0] shdn_sync_reg;
	logic [1:0] regulator_on_n_sync_reg;
	logic [1:0] hold_sync_reg;
	logic [1:0] vlow_sync_reg;
	logic [2:0] kick_sync_reg;
	logic [7:0] contact_m_reg;
	logic [7:0] contact_s_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cs_sync_reg    <= 3'h7;
			shdn_sync_reg  <= 2'h0;
			regulator_on_n_sync_reg <= 2'h3;
			hold_sync_reg  <= 2'h0;
			vlow_sync_reg  <= 2'h0;
		end else begin
			cs_sync_reg    <= {cs_sync_reg[1:0], cs_n};
			shdn_sync_reg  <= {shdn_sync_reg[0], shutdown_n};
			regulator_on_n_sync_reg <= {regulator_on_n_sync_reg[0], regulator_on_n};
			hold_sync_reg  <= {hold_sync_reg[0], regulator_hold_n};
			vlow_sync_reg  <= {vlow_sync_reg[0], regulator_output_low};
		end
	end

	// Third stage only feeds the edge detector, never the first
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			kick_sync_reg <= 3'h0;
		end else begin
			kick_sync_reg <= {kick_sync_reg[1:0], watchdog_kick};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < cmc_pkg::CONTACTS; gi++) begin : g_contact
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					contact_m_reg[gi] <= 1'b0;
					contact_s_reg[gi] <= 1'b0;
				end else begin
					contact_m_reg[gi] <= contact[gi];
					contact_s_reg[gi] <= contact_m_reg[gi];
				end
			end
		end
	endgenerate

	logic shutdown_s;
	logic regulator_on_n_s;
	logic hold_s;
	logic vlow_s;
	logic kick_edge;
	logic cs_rise;
	logic cs_idle;

	assign shutdown_s = shdn_sync_reg[1];
	assign regulator_on_n_s    = regulator_on_n_sync_reg[1];
	assign hold_s     = hold_sync_reg[1];
	assign vlow_s     = vlow_sync_reg[1];
	assign kick_edge  = kick_sync_reg[2] ^ kick_sync_reg[1];
	assign cs_rise    = cs_sync_reg[1] & ~cs_sync_reg[2];
	assign cs_idle    = cs_sync_reg[1];

	// Frame end: the link word is frozen once chip select is high
	logic       cmd_load;
	logic       frame_done;
	logic [7:0] mask_reg;
	logic       wetting_enable;

	assign frame_done = cs_rise && (lk.rx_count != 5'h00);
	// Short or long frames are dropped to keep the command intact
	assign cmd_load = cs_rise && (lk.rx_count == cmc_pkg::FRAME_COUNT);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask_reg       <= cmc_pkg::MASK_RESET;
			wetting_enable <= cmc_pkg::WET_RESET;
		end else if (cmd_load) begin
			mask_reg <=
				lk.rx_word[cmc_pkg::CMD_MASK_MSB:cmc_pkg::CMD_MASK_LSB];
			wetting_enable <= lk.rx_word[cmc_pkg::CMD_WET_BIT];
		end
	end

	// Status, with pass-through contacts hidden
	logic [7:0] status;
	assign status = wetting_enable ? contact_s_reg
		: {contact_s_reg[7:2], 2'b00};

	// Snapshot frozen while a frame runs; host waits 230 ns, over four clocks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lk.tx_word <= 16'h0000;
		end else if (cs_idle) begin
			lk.tx_word <= {cmc_pkg::STATUS_PAD, status};
		end
	end

	// Contact change detection
	logic [7:0] prev_reg;
	logic [7:0] chg;
	logic [7:0] pass_mask;
	logic       change_pend_reg;

	assign pass_mask = wetting_enable ? 8'h00 : 8'h03;
	assign chg = (contact_s_reg ^ prev_reg) & ~mask_reg & ~pass_mask
		& {8{shutdown_s}};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev_reg <= 8'h00;
		end else begin
			prev_reg <= contact_s_reg;
		end
	end

	// A change in the read's own cycle survives the read
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			change_pend_reg <= 1'b0;
		end else if (|chg) begin
			change_pend_reg <= 1'b1;
		end else if (frame_done) begin
			change_pend_reg <= 1'b0;
		end
	end

	// Regulator: shutdown, then regulator-on, take priority; otherwise hold high keeps its state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regulator_enable <= 1'b0;
			shutdown_mode    <= 1'b1;
		end else begin
			shutdown_mode <= ~shutdown_s;
			if (!shutdown_s) begin
				regulator_enable <= 1'b0;
			end else if (!regulator_on_n_s) begin
				regulator_enable <= 1'b1;
			end else if (!hold_s) begin
				regulator_enable <= 1'b0;
			end
		end
	end

	// Watchdog
	cmc_pkg::cmc_wd_e wd_state;
	logic [21:0]      wd_cnt;
	logic [21:0]      pulse_cnt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wd_state  <= cmc_pkg::CMC_WD_RUN;
			wd_cnt    <= 22'h000000;
			pulse_cnt <= 22'h000000;
		end else begin
			unique case (wd_state)
				cmc_pkg::CMC_WD_RUN: begin
					if (kick_edge) begin
						wd_cnt <= 22'h000000;
					end else begin
						wd_cnt <= wd_cnt + 22'h000001;
						if (wd_cnt == WD1_LAST) begin
							wd_state <= cmc_pkg::CMC_WD_ALERT;
						end
					end
				end
				cmc_pkg::CMC_WD_ALERT: begin
					if (kick_edge) begin
						wd_cnt   <= 22'h000000;
						wd_state <= cmc_pkg::CMC_WD_RUN;
					end else if (wd_cnt == WD2_LAST) begin
						wd_cnt    <= 22'h000000;
						pulse_cnt <= 22'h000000;
						wd_state  <= cmc_pkg::CMC_WD_RESET;
					end else begin
						wd_cnt <= wd_cnt + 22'h000001;
					end
				end
				cmc_pkg::CMC_WD_RESET: begin
					// Kicks during the pulse only clear wd_cnt, which the pulse end clears anyway
					if (kick_edge) begin
						wd_cnt <= 22'h000000;
					end
					if (pulse_cnt == RST_LAST) begin
						wd_state <= cmc_pkg::CMC_WD_RUN;
						wd_cnt   <= 22'h000000;
					end else begin
						pulse_cnt <= pulse_cnt + 22'h000001;
					end
				end
				default: begin
					wd_state <= cmc_pkg::CMC_WD_RUN;
				end
			endcase
		end
	end

	// Open-drain pins: level fixed low, only the enable moves
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alert_n_o  <= 1'b0;
			reset_n_o  <= 1'b0;
			alert_n_oe <= 1'b0;
			reset_n_oe <= 1'b0;
		end else begin
			alert_n_o  <= 1'b0;
			reset_n_o  <= 1'b0;
			alert_n_oe <= (wd_state == cmc_pkg::CMC_WD_ALERT)
				| change_pend_reg;
			reset_n_oe <= (wd_state == cmc_pkg::CMC_WD_RESET) | vlow_s;
		end
	end

	// Direct outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			direct_out_0 <= cmc_pkg::DIRECT_IDLE;
			direct_out_1 <= cmc_pkg::DIRECT_IDLE;
		end else if (!wetting_enable) begin
			direct_out_0 <= contact_s_reg[0];
			direct_out_1 <= contact_s_reg[1];
		end else begin
			direct_out_0 <= cmc_pkg::DIRECT_IDLE;
			direct_out_1 <= cmc_pkg::DIRECT_IDLE;
		end
	end

	AST_SHDN_OFF: assert property (
		@(posedge clk_sys) disable iff (rst)
		!shutdown_s |=> !regulator_enable && shutdown_mode
	) else $error("Regulator on during shutdown");

	AST_REGULATOR_ON_N: assert property (
		@(posedge clk_sys) disable iff (rst)
		shutdown_s && !regulator_on_n_s |=> regulator_enable
	) else $error("Regulator not enabled by regulator-on");

	AST_HOLD: assert property (
		@(posedge clk_sys) disable iff (rst)
		regulator_enable && hold_s && shutdown_s |=> regulator_enable
	) else $error("Regulator dropped while hold high");

	AST_CMD_ON_RISE: assert property (
		@(posedge clk_sys) disable iff (rst)
		$changed(wetting_enable) |-> $past(cmd_load)
	) else $error("Command changed outside chip select rise");

	AST_WD_RESET_OUT: assert property (
		@(posedge clk_sys) disable iff (rst)
		wd_state == cmc_pkg::CMC_WD_RESET |=> reset_n_oe
	) else $error("Reset not driven during watchdog pulse");

	AST_DIRECT: assert property (
		@(posedge clk_sys) disable iff (rst)
		!wetting_enable |=> direct_out_0 == $past(contact_s_reg[0])
			&& direct_out_1 == $past(contact_s_reg[1])
	) else $error("Direct output not following contact");

	AST_KICK_RESTART: assert property (
		@(posedge clk_sys) disable iff (rst)
		kick_edge && wd_state != cmc_pkg::CMC_WD_RESET |=> wd_cnt == 22'h0
	) else $error("Kick did not restart watchdog");

	AST_WD_ALERT: assert property (
		@(posedge clk_sys) disable iff (rst)
		wd_state == cmc_pkg::CMC_WD_RUN && wd_cnt == WD1_LAST && !kick_edge
		|-> ##2 alert_n_oe
	) else $error("Alert missing after first timeout");

	AST_READ_RELEASE: assert property (
		@(posedge clk_sys) disable iff (rst)
		frame_done && !(|chg) && wd_state != cmc_pkg::CMC_WD_ALERT
		##1 wd_state != cmc_pkg::CMC_WD_ALERT && !(|chg) |=> !alert_n_oe
	) else $error("Read did not release alert");

	AST_PASS_QUIET: assert property (
		@(posedge clk_sys) disable iff (rst)
		!wetting_enable |-> chg[1:0] == 2'b00 && status[1:0] == 2'b00
	) else $error("Pass-through contact reported");

endmodule // cmc_top

/* shared/cmc_link_if.sv */
`timescale 1ns/10ps
interface cmc_link_if;
	logic [15:0] rx_word;
	logic [4:0]  rx_count;
	logic [15:0] tx_word;

	modport link (
		output rx_word,
		output rx_count,
		input  tx_word
	);

	modport core (
		input  rx_word,
		input  rx_count,
		output tx_word
	);
endinterface

/* shared/cmc_pkg.sv */
package cmc_pkg;

	// Serial frame
	localparam int          FRAME_BITS    = 16;
	localparam logic [4:0]  FRAME_COUNT   = 5'h10;
	localparam logic [4:0]  COUNT_MAX     = 5'h1f;

	// Command word field positions
	localparam int          CMD_MASK_LSB  = 0;
	localparam int          CMD_MASK_MSB  = 7;
	localparam int          CMD_WET_BIT   = 8;

	// Reset values: no channel masked, channels 2-7 may alert, contacts 0/1 pass through
	localparam logic [7:0]  MASK_RESET    = 8'h00;
	localparam logic        WET_RESET     = 1'b0;

	// Status word: contact levels in the low byte, the rest reads zero
	localparam logic [7:0]  STATUS_PAD    = 8'h00;

	// Idle level of a direct output while it is not passing through
	localparam logic        DIRECT_IDLE   = 1'b1;

	// Number of monitored contacts
	localparam int          CONTACTS      = 8;

	// Watchdog timing at the typical timing capacitor
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          WD1_MS        = 84;
	localparam int          RST_MS        = 21;
	localparam int          WD1_CYCLES    = WD1_MS * (CLK_HZ / 1000);
	localparam int          WD2_CYCLES    = 2 * WD1_CYCLES;
	localparam int          RST_CYCLES    = RST_MS * (CLK_HZ / 1000);
	localparam int          WD_CNT_W      = 22;

	typedef enum logic [1:0] {
		CMC_WD_RUN,
		CMC_WD_ALERT,
		CMC_WD_RESET
	} cmc_wd_e;

endpackage
